// file: hdl/wcp_port.sv
// module: word channel peripheral port, device end
`timescale 1ns/100ps
module wcp_port #(
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // configuration
    input wire logic [3:0] equip_num_in,
    // computer channel
    input wire wcp_pkg::wcp_chan_req_t chan_in,
    output wcp_pkg::wcp_chan_ans_t chan_out,
    output logic interrupt_out,
    // medium, words from the computer
    output logic [15:0] med_tx_data_out,
    output logic med_tx_valid_out,
    input wire logic med_tx_ready_in,
    // medium, words to the computer
    input wire logic [15:0] med_rx_data_in,
    input wire logic med_rx_valid_in,
    output logic med_rx_ready_out,
    // medium control and conditions
    input wire wcp_pkg::wcp_med_stat_t med_in,
    output logic motion_out,
    output logic read_mode_out
);

    // ===========================================================
    // state
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_HOLD = 3'b100
    } wcp_phase_t;

    typedef struct packed {
        wcp_phase_t phase;
        logic [wcp_pkg::CNT_W-1:0] cnt;
        logic dec_rply;
        logic [15:0] rdata;
        logic reply;
        logic reject;
        logic data_req;
        logic eop_req;
        logic alarm_req;
        logic data_rsp;
        logic eop_rsp;
        logic alarm_rsp;
        logic irq;
        logic motion;
        logic busy;
        logic lost;
        logic parity;
        logic rd_mode;
        logic [1:0] tx_cnt;
        logic [1:0][15:0] tx_buf;
        logic tx_wp;
        logic tx_rp;
        logic [1:0] rx_cnt;
        logic [1:0][15:0] rx_buf;
        logic rx_wp;
        logic rx_rp;
    } wcp_state_t;

    wcp_state_t s_q, s_d;

    // ===========================================================
    // decode
    logic strobe, selected, dir_hi, stn_zero, can_move;
    logic tx_push, tx_pop, rx_push, rx_pop, data_ok, alarm_now, eop_now;
    logic [15:0] fn, status;

    assign strobe = chan_in.rd | chan_in.wr;
    assign selected = chan_in.addr[wcp_pkg::ADDR_EQ_LSB +: wcp_pkg::ADDR_EQ_W]
        == equip_num_in;
    assign dir_hi = chan_in.addr[wcp_pkg::ADDR_DIR_BIT];
    assign stn_zero = ~chan_in.addr[wcp_pkg::ADDR_STN_BIT];
    assign fn = chan_in.wdata;
    // data possible: room to write or a word to read
    assign data_ok = s_q.rd_mode ? (s_q.rx_cnt != 2'd0)
                                 : (s_q.tx_cnt != 2'(DEPTH));
    assign can_move = med_in.ready & data_ok &
        (chan_in.rd ? s_q.rd_mode : ~s_q.rd_mode);
    assign alarm_now = s_q.lost | s_q.parity | med_in.warn | ~med_in.ready;
    assign eop_now = ~s_q.busy;

    assign tx_pop = med_tx_ready_in & (s_q.tx_cnt != 2'd0);
    assign rx_push = med_rx_valid_in & (s_q.rx_cnt != 2'(DEPTH));

    always_comb begin
        status = wcp_pkg::RST_WORD;
        status[wcp_pkg::ST_READY] = med_in.ready;
        status[wcp_pkg::ST_BUSY] = s_q.busy;
        status[wcp_pkg::ST_INT] = s_q.irq;
        status[wcp_pkg::ST_DATA] = data_ok;
        status[wcp_pkg::ST_EOP] = eop_now;
        status[wcp_pkg::ST_ALARM] = alarm_now;
        status[wcp_pkg::ST_LOST] = s_q.lost;
        status[wcp_pkg::ST_PROT] = med_in.protect;
        status[wcp_pkg::ST_PARITY] = s_q.parity;
    end

    // ===========================================================
    // next state
    always_comb begin
        s_d = s_q;
        tx_push = 1'b0;
        rx_pop = 1'b0;
        if (s_q.reply | s_q.reject) begin
            s_d.cnt = '0;
        end
        unique case (s_q.phase)
            ST_IDLE: begin
                if (strobe && selected) begin
                    s_d.phase = ST_WAIT;
                    s_d.cnt = '0;
                end
            end
            ST_WAIT: begin
                s_d.cnt = s_q.cnt + 1'b1;
                // hold answer back the least time, decide once
                if (!strobe) begin
                    s_d.phase = ST_IDLE;
                end else if (s_q.cnt == wcp_pkg::CNT_W'(
                        wcp_pkg::ANS_MIN_CYC - 1)) begin
                    s_d.phase = ST_HOLD;
                    if (dir_hi && stn_zero && chan_in.wr) begin
                        if (fn[wcp_pkg::FN_CLR_CTRL]) begin
                            s_d.motion = 1'b0;
                            s_d.lost = 1'b0;
                            s_d.parity = 1'b0;
                            s_d.busy = 1'b0;
                            s_d.rd_mode = 1'b1;
                        end
                        if (fn[wcp_pkg::FN_CLR_CTRL] |
                                fn[wcp_pkg::FN_CLR_INT]) begin
                            s_d.data_req = 1'b0;
                            s_d.eop_req = 1'b0;
                            s_d.alarm_req = 1'b0;
                            s_d.data_rsp = 1'b0;
                            s_d.eop_rsp = 1'b0;
                            s_d.alarm_rsp = 1'b0;
                        end
                        // set after clear
                        if (fn[wcp_pkg::FN_DATA_INT]) s_d.data_req = 1'b1;
                        if (fn[wcp_pkg::FN_EOP_INT]) begin
                            s_d.eop_req = 1'b1;
                            // already ended ops do not fire
                            s_d.eop_rsp = 1'b0;
                        end
                        if (fn[wcp_pkg::FN_ALARM_INT]) begin
                            s_d.alarm_req = 1'b1;
                            s_d.alarm_rsp = alarm_now;
                        end
                        if (fn[wcp_pkg::FN_STOP]) begin
                            s_d.motion = 1'b0;
                        end else if (fn[wcp_pkg::FN_START] && med_in.ready) begin
                            s_d.motion = 1'b1;
                            s_d.busy = 1'b1;
                        end
                        s_d.reply = 1'b1;
                    end else if (dir_hi && stn_zero && chan_in.rd) begin
                        s_d.rdata = status;
                        s_d.reply = 1'b1;
                    end else if (!dir_hi && can_move) begin
                        if (chan_in.wr) begin
                            tx_push = 1'b1;
                        end else begin
                            s_d.rdata = s_q.rx_buf[s_q.rx_rp];
                            rx_pop = 1'b1;
                        end
                        s_d.data_rsp = 1'b0;
                        s_d.reply = 1'b1;
                    end else begin
                        s_d.reject = 1'b1;
                    end
                end
            end
            ST_HOLD: begin
                if (!strobe) begin
                    s_d.phase = ST_IDLE;
                    s_d.reply = 1'b0;
                    s_d.reject = 1'b0;
                    s_d.rdata = '0;
                end
            end
        endcase
        // buffers
        if (tx_push) begin
            s_d.tx_buf[s_q.tx_wp] = fn;
            s_d.tx_wp = ~s_q.tx_wp;
        end
        if (tx_pop) s_d.tx_rp = ~s_q.tx_rp;
        s_d.tx_cnt = s_q.tx_cnt + 2'(tx_push) - 2'(tx_pop);
        if (rx_push) begin
            s_d.rx_buf[s_q.rx_wp] = med_rx_data_in;
            s_d.rx_wp = ~s_q.rx_wp;
        end
        if (rx_pop) s_d.rx_rp = ~s_q.rx_rp;
        s_d.rx_cnt = s_q.rx_cnt + 2'(rx_push) - 2'(rx_pop);
        // overrun: word arrives with hold full
        if (med_rx_valid_in && s_q.rx_cnt == 2'(DEPTH) && s_q.rd_mode)
            s_d.lost = 1'b1;
        if (med_in.parity_err) s_d.parity = 1'b1;
        // end of operation
        if (med_in.eop_event && s_q.tx_cnt == 2'd0) begin
            s_d.busy = 1'b0;
            s_d.motion = 1'b0;
            if (s_d.eop_req && s_q.busy) s_d.eop_rsp = 1'b1;
        end
        // responses, the reply clear wins over the data set
        // use the next request so a clear in this cycle leaves no response
        if (s_d.data_req && data_ok && !rx_pop && !tx_push)
            s_d.data_rsp = 1'b1;
        if (s_d.alarm_req && alarm_now) s_d.alarm_rsp = 1'b1;
        s_d.irq = (s_d.data_req & s_d.data_rsp) | (s_d.eop_req & s_d.eop_rsp)
            | (s_d.alarm_req & s_d.alarm_rsp);
    end

    // ===========================================================
    // registers
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_q <= '0;
            s_q.phase <= ST_IDLE;
            s_q.rd_mode <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ===========================================================
    // outputs
    assign chan_out.rdata = s_q.rdata;
    assign chan_out.reply = s_q.reply;
    assign chan_out.reject = s_q.reject;
    assign interrupt_out = s_q.irq;
    assign motion_out = s_q.motion;
    assign read_mode_out = s_q.rd_mode;
    assign med_tx_data_out = s_q.tx_buf[s_q.tx_rp];
    assign med_tx_valid_out = s_q.tx_cnt != 2'd0;
    assign med_rx_ready_out = s_q.rx_cnt != 2'(DEPTH);

    // ===========================================================
    // checks
    sequence seq_strobe_rise;
        $rose(strobe) && selected;
    endsequence

    sequence seq_answer;
        chan_out.reply || chan_out.reject;
    endsequence

    a_answer_bound: assert property (@(posedge clock_in) disable iff (!nrst_in)
        seq_strobe_rise |-> ##[1:60] seq_answer)
        else $error("strobe not answered in time");

    a_answer_drop: assert property (@(posedge clock_in) disable iff (!nrst_in)
        seq_answer ##0 !strobe |=> !seq_answer)
        else $error("answer held after strobe fell");

    a_not_ready_rej: assert property (@(posedge clock_in)
        disable iff (!nrst_in)
        s_q.phase == ST_WAIT && !dir_hi && !med_in.ready && strobe &&
        s_q.cnt == wcp_pkg::CNT_W'(wcp_pkg::ANS_MIN_CYC - 1)
        |=> chan_out.reject)
        else $error("not ready data strobe not rejected");

    a_one_answer: assert property (@(posedge clock_in) disable iff (!nrst_in)
        !(chan_out.reply && chan_out.reject))
        else $error("reply and reject together");

    a_irq_cause: assert property (@(posedge clock_in) disable iff (!nrst_in)
        interrupt_out |-> (s_q.data_rsp || s_q.eop_rsp || s_q.alarm_rsp))
        else $error("interrupt without response");

    a_stop_wins: assert property (@(posedge clock_in) disable iff (!nrst_in)
        tx_push == 1'b0 && s_q.phase == ST_WAIT && dir_hi && chan_in.wr &&
        stn_zero && fn[wcp_pkg::FN_STOP] && s_d.phase == ST_HOLD
        |=> !motion_out)
        else $error("stop did not win");

    a_clear_int: assert property (@(posedge clock_in) disable iff (!nrst_in)
        s_q.phase == ST_WAIT && s_d.phase == ST_HOLD && dir_hi && stn_zero &&
        chan_in.wr && fn[wcp_pkg::FN_CLR_INT] && fn[4:2] == 3'h0
        |=> !s_q.data_req && !s_q.eop_req && !s_q.alarm_req)
        else $error("clear interrupt left a request");

    a_alarm_now: assert property (@(posedge clock_in) disable iff (!nrst_in)
        s_q.alarm_req && s_d.alarm_req && alarm_now |=> s_q.alarm_rsp)
        else $error("alarm response late");

endmodule : wcp_port

// file: hdl/wcp_pkg.sv
// package: constants and carrier types for the word channel peripheral port
package wcp_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;

    // address word layout
    localparam int ADDR_DIR_BIT = 0;
    localparam int ADDR_EQ_LSB = 7;
    localparam int ADDR_EQ_W = 4;
    localparam int ADDR_STN_BIT = 6;

    // function command word bits
    localparam int FN_CLR_CTRL = 0;
    localparam int FN_CLR_INT = 1;
    localparam int FN_DATA_INT = 2;
    localparam int FN_EOP_INT = 3;
    localparam int FN_ALARM_INT = 4;
    localparam int FN_START = 5;
    localparam int FN_STOP = 6;

    // equipment status word bits
    localparam int ST_READY = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_INT = 2;
    localparam int ST_DATA = 3;
    localparam int ST_EOP = 4;
    localparam int ST_ALARM = 5;
    localparam int ST_LOST = 6;
    localparam int ST_PROT = 7;
    localparam int ST_PARITY = 8;

    // timing: answer within 4 us, at least 200 ns after the strobe
    localparam int CLK_PERIOD_PS = 4000;
    localparam int ANS_MAX_NS = 4000;
    localparam int ANS_MIN_NS = 200;
    localparam int ANS_MAX_CYC = (ANS_MAX_NS * 1000) / CLK_PERIOD_PS;
    localparam int ANS_MIN_CYC =
        (ANS_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 11;

    localparam logic [15:0] RST_WORD = 16'h0000;

    // channel side request and answer
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic rd;
        logic wr;
    } wcp_chan_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic reply;
        logic reject;
    } wcp_chan_ans_t;

    // medium side conditions
    typedef struct packed {
        logic ready;
        logic protect;
        logic parity_err;
        logic warn;
        logic eop_event;
    } wcp_med_stat_t;

endpackage : wcp_pkg

// file: dv/wcp_chan_model.sv
// channel model: computer side strobes for the word channel port
`timescale 1ns/100ps
module wcp_chan_model (
    // clock
    input wire logic clock_in,
    // channel
    output wcp_pkg::wcp_chan_req_t req_out,
    input wire wcp_pkg::wcp_chan_ans_t ans_in
);
    // ========================================
    // strobe sequencing
    initial req_out = '0;

    // res is {reply, reject}; 00 means nothing came inside the time limit
    task automatic xfer(input logic [15:0] addr, input logic [15:0] data,
                        input logic wr, output logic [1:0] res,
                        output logic [15:0] rdata);
        int n;
        n = 0;
        @(posedge clock_in);
        req_out <= '{addr: addr, wdata: data, rd: !wr, wr: wr};
        // answer is taken at the rising edge where it is seen high
        do begin
            @(posedge clock_in);
            n++;
        end while (!(ans_in.reply || ans_in.reject) && n < 1100);
        res = {ans_in.reply, ans_in.reject};
        rdata = ans_in.rdata;
        // released lines show the inverse so stale data cannot pass
        req_out <= '{addr: ~addr, wdata: ~data, rd: 1'b0, wr: 1'b0};
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while ((ans_in.reply || ans_in.reject) && n < 8);
    endtask : xfer
endmodule : wcp_chan_model

// file: dv/wcp_port_tb.sv
// testbench: word channel peripheral port against a channel model
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module wcp_port_tb;
    // ========================================
    // wiring
    localparam logic [15:0] DAT_A = 16'h0080;
    localparam logic [15:0] ST_A = 16'h0081;
    logic clock_in;
    logic nrst_in;
    logic rx_valid;
    logic tx_ready;
    logic intr;
    logic motion;
    logic rd_mode;
    logic rx_rdy;
    logic [15:0] rx_data;
    int fails = 0;
    int n_checks = 0;
    wcp_pkg::wcp_med_stat_t med;
    wcp_pkg::wcp_chan_req_t req;
    wcp_pkg::wcp_chan_ans_t ans;

    wcp_port i_dut (.clock_in(clock_in), .nrst_in(nrst_in),
        .equip_num_in(4'h1), .chan_in(req), .chan_out(ans),
        .interrupt_out(intr), .med_tx_data_out(), .med_tx_valid_out(),
        .med_tx_ready_in(tx_ready), .med_rx_data_in(rx_data),
        .med_rx_valid_in(rx_valid), .med_rx_ready_out(rx_rdy),
        .med_in(med), .motion_out(motion), .read_mode_out(rd_mode));
    wcp_chan_model i_chan (.clock_in(clock_in), .req_out(req), .ans_in(ans));

    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    // ========================================
    // helpers
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic xf(input logic [15:0] a, input logic [15:0] d,
                      input logic wr, input logic [1:0] er,
                      input logic [15:0] ed);
        logic [1:0] r;
        logic [15:0] q;
        i_chan.xfer(a, d, wr, r, q);
        `CHK(r, er)
        if (er == 2'b10 && !wr) `CHK(q, ed)
        repeat (3) @(posedge clock_in);
    endtask : xf

    // the medium cannot stall, so a word is offered for one cycle only
    task automatic push(input logic [15:0] w);
        @(posedge clock_in);
        rx_data <= w;
        rx_valid <= 1'b1;
        @(posedge clock_in);
        rx_data <= ~w;
        rx_valid <= 1'b0;
        repeat (2) @(posedge clock_in);
    endtask : push

    // ========================================
    // scenarios
    task automatic t_reset();
        @(posedge clock_in);
        `CHK({rd_mode, rx_rdy, motion, intr}, 4'b1100)
        xf(ST_A, 16'h0000, 1'b0, 2'b10, 16'h0030);
        xf(DAT_A, 16'h0000, 1'b0, 2'b01, 16'h0000);
        med.ready <= 1'b1;
        xf(ST_A, 16'h0000, 1'b0, 2'b10, 16'h0011);
        xf(16'h0101, 16'h0000, 1'b0, 2'b00, 16'h0000);
        xf(DAT_A, 16'h1234, 1'b1, 2'b01, 16'h0000);
    endtask : t_reset

    task automatic t_stream();
        push(16'hA5C3);
        push(16'h5A3C);
        `CHK(rx_rdy, 1'b0)
        xf(ST_A, 16'h0000, 1'b0, 2'b10, 16'h0019);
        push(16'h0F0F);
        xf(ST_A, 16'h0000, 1'b0, 2'b10, 16'h0079);
        xf(DAT_A, 16'h0000, 1'b0, 2'b10, 16'hA5C3);
        xf(DAT_A, 16'h0000, 1'b0, 2'b10, 16'h5A3C);
        xf(DAT_A, 16'h0000, 1'b0, 2'b01, 16'h0000);
        xf(ST_A, 16'h0000, 1'b0, 2'b10, 16'h0071);
        xf(ST_A, 16'h0001, 1'b1, 2'b10, 16'h0000);
        xf(ST_A, 16'h0000, 1'b0, 2'b10, 16'h0011);
    endtask : t_stream

    task automatic t_irq();
        med.warn <= 1'b1;
        xf(ST_A, 16'h0010, 1'b1, 2'b10, 16'h0000);
        `CHK(intr, 1'b1)
        xf(ST_A, 16'h0000, 1'b0, 2'b10, 16'h0035);
        xf(ST_A, 16'h0012, 1'b1, 2'b10, 16'h0000);
        `CHK(intr, 1'b1)
        xf(ST_A, 16'h0002, 1'b1, 2'b10, 16'h0000);
        `CHK(intr, 1'b0)
        med.warn <= 1'b0;
        push(16'h1357);
        xf(ST_A, 16'h0004, 1'b1, 2'b10, 16'h0000);
        `CHK(intr, 1'b1)
        xf(DAT_A, 16'h0000, 1'b0, 2'b10, 16'h1357);
        `CHK(intr, 1'b0)
        xf(ST_A, 16'h0001, 1'b1, 2'b10, 16'h0000);
    endtask : t_irq

    task automatic t_motion();
        xf(ST_A, 16'h0020, 1'b1, 2'b10, 16'h0000);
        `CHK(motion, 1'b1)
        xf(ST_A, 16'h0000, 1'b0, 2'b10, 16'h0003);
        xf(ST_A, 16'h0008, 1'b1, 2'b10, 16'h0000);
        `CHK(intr, 1'b0)
        med.eop_event <= 1'b1;
        @(posedge clock_in);
        med.eop_event <= 1'b0;
        repeat (3) @(posedge clock_in);
        `CHK(intr, 1'b1)
        xf(ST_A, 16'h0000, 1'b0, 2'b10, 16'h0015);
        xf(ST_A, 16'h0060, 1'b1, 2'b10, 16'h0000);
        `CHK(motion, 1'b0)
        xf(ST_A, 16'h0001, 1'b1, 2'b10, 16'h0000);
        xf(ST_A, 16'h0008, 1'b1, 2'b10, 16'h0000);
        `CHK(intr, 1'b0)
    endtask : t_motion

    task automatic t_flags();
        med.protect <= 1'b1;
        med.parity_err <= 1'b1;
        @(posedge clock_in);
        med.parity_err <= 1'b0;
        xf(ST_A, 16'h0000, 1'b0, 2'b10, 16'h01B1);
        xf(ST_A, 16'hFF80, 1'b1, 2'b10, 16'h0000);
        xf(ST_A, 16'h0000, 1'b0, 2'b10, 16'h01B1);
        `CHK(motion, 1'b0)
        xf(ST_A, 16'h0001, 1'b1, 2'b10, 16'h0000);
        xf(ST_A, 16'h0000, 1'b0, 2'b10, 16'h0091);
    endtask : t_flags

    // ========================================
    // main sequence and watchdog
    initial begin
        nrst_in = 1'b0;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
        rx_data = 16'hFFFF;
        med = '0;
        repeat (6) @(posedge clock_in);
        nrst_in <= 1'b1;
        t_reset();
        t_stream();
        t_irq();
        t_motion();
        t_flags();
        end_sim();
    end

    // the run needs about 3000 cycles; over thirteen times that means a hang
    initial begin
        repeat (40000) @(posedge clock_in);
        fails++;
        end_sim();
    end
endmodule : wcp_port_tb
